// file: fst_pkg.sv
package fst_pkg;
	// clock rate and time units
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned MS_PER_S = 1000;
	// delay figures in milliseconds
	localparam int unsigned ON_SHORT_MS = 1000;
	localparam int unsigned ON_LONG_MS = 2000;
	localparam int unsigned OFF_SHORT_MS = 3200;
	localparam int unsigned OFF_LONG_MS = 6500;
	localparam int unsigned CHECK_PERIOD_MS = 10000;
	localparam int unsigned CHECK_VIEW_MS = 9000;
	localparam int unsigned CHECK_BLOCK_MS = 1000;
	// cycle counts derived from the rate
	localparam longint unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam longint unsigned ON_SHORT_CYC = ON_SHORT_MS * CYC_PER_MS;
	localparam longint unsigned ON_LONG_CYC = ON_LONG_MS * CYC_PER_MS;
	localparam longint unsigned OFF_SHORT_CYC = OFF_SHORT_MS * CYC_PER_MS;
	localparam longint unsigned OFF_LONG_CYC = OFF_LONG_MS * CYC_PER_MS;
	localparam longint unsigned PERIOD_CYC = CHECK_PERIOD_MS * CYC_PER_MS;
	localparam longint unsigned VIEW_CYC = CHECK_VIEW_MS * CYC_PER_MS;
	// number of failed checks in a row that declares a fault
	localparam int unsigned FAIL_LIMIT = 2;
	// meter selector codes
	typedef enum logic [1:0] {
		FST_METER_OFF,
		FST_METER_SIGNAL,
		FST_METER_SETPOINT
	} fst_meter_sel_t;
	// jumper straps
	typedef struct packed {
		logic turn_on_delay_select;
		logic turn_off_delay_select;
		logic interlock_enable_link;
		logic independent_relay_link;
		logic current_output_link;
	} fst_links_t;
	// relay and indicator drive
	typedef struct packed {
		logic fault_relay;
		logic aux_flame_relay;
		logic flame_on_relay;
		logic fault_led;
		logic aux_flame_led;
		logic flame_on_led;
		logic check_led;
	} fst_outs_t;
endpackage

// file: fst_cycle_timer.sv
`timescale 1ns/10ps
// loadable down counter; done pulses when the count expires
module fst_cycle_timer
	import fst_pkg::*;
#(
	parameter int W = 32
)(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	input wire logic cancel_i,
	input wire logic [W-1:0] load_i,
	output logic busy_o,
	output logic done_o
);
	logic [W-1:0] cnt_q;
	logic busy_q;
	logic done_q;
	wire last_w = busy_q && (cnt_q == {{(W-1){1'b0}}, 1'b1});

	// count down, restart on start, drop on cancel
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= last_w && !cancel_i && !start_i;
			if (start_i)
			begin
				cnt_q <= load_i;
				busy_q <= 1'b1;
			end
			else if (cancel_i || last_w)
			begin
				busy_q <= 1'b0;
			end
			else if (busy_q)
			begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
endmodule

// file: fst_supervisor.sv
`timescale 1ns/10ps
// Contract
// - A rise above threshold starts a turn-on delay of one or two seconds.
// - Flame relays and flame indicators energize only if flame held for the delay.
// - A drop starts a 3.2 or 6.5 s turn-off delay after which the flame relays and lamps go off.
// - The check cycle repeats every 10 s: 9 s viewing, 1 s blocked.
// - The check indicator is lit during the blocked second of each cycle.
// - Self-test supervision is armed only while flame is above threshold.
// - Two successive checks without a drop energize fault relay and lamp.
// - Flame outputs ride through the blocked second thanks to the delay.
// - With interlock, a fault drops both flame relays and flame lamps.
// - Gain select low picks channel one, high channel two, only one active.
// - Meter shows signal, nothing or setpoint; remote meter always signal.
// - The signal output is either voltage or current, never both.
// - Turn-on jumper installed gives 2 s, removed gives 1 s.
// - Turn-off jumper installed gives 6.5 s, absent gives 3.2 s.
// - Interlock needs its link in and the companion link out.
module fst_supervisor
	import fst_pkg::*;
#(
	parameter int SIG_W = 8,
	parameter longint unsigned ON_SHORT = ON_SHORT_CYC,
	parameter longint unsigned ON_LONG = ON_LONG_CYC,
	parameter longint unsigned OFF_SHORT = OFF_SHORT_CYC,
	parameter longint unsigned OFF_LONG = OFF_LONG_CYC,
	parameter longint unsigned PERIOD = PERIOD_CYC,
	parameter longint unsigned VIEW = VIEW_CYC
)(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [SIG_W-1:0] gain1_signal_i,
	input wire logic [SIG_W-1:0] gain2_signal_i,
	input wire logic gain_select_i,
	input wire logic [SIG_W-1:0] setpoint_i,
	input wire fst_meter_sel_t meter_sel_i,
	input wire fst_links_t links_i,
	output fst_outs_t outs_o,
	output logic [SIG_W-1:0] panel_meter_o,
	output logic [SIG_W-1:0] remote_meter_o,
	output logic voltage_out_en_o,
	output logic current_out_en_o,
	output logic chopper_block_o
);
	localparam int TW = 32;

	wire [SIG_W-1:0] flame_sig_w = gain_select_i ? gain2_signal_i
		: gain1_signal_i;
	wire above_w = flame_sig_w > setpoint_i;

	wire [TW-1:0] on_load_w = links_i.turn_on_delay_select ?
		TW'(ON_LONG) : TW'(ON_SHORT);
	wire [TW-1:0] off_load_w = links_i.turn_off_delay_select ?
		TW'(OFF_LONG) : TW'(OFF_SHORT);
	wire interlock_w = links_i.interlock_enable_link
		&& !links_i.independent_relay_link;

	logic above_q;
	logic flame_q;
	logic fault_q;
	logic [1:0] fails_q;
	logic [TW-1:0] cyc_q;
	logic seen_drop_q;
	logic armed_q;
	fst_outs_t outs_q;
	logic [SIG_W-1:0] panel_q;
	logic [SIG_W-1:0] remote_q;
	logic volt_q;
	logic curr_q;
	logic block_q;

	wire rise_w = above_w && !above_q;
	wire fall_w = !above_w && above_q;
	logic on_done;
	logic off_done;

	fst_cycle_timer #(.W(TW)) u_on_timer (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(rise_w),
		.cancel_i(fall_w),
		.load_i(on_load_w),
		.busy_o(),
		.done_o(on_done)
	);

	fst_cycle_timer #(.W(TW)) u_off_timer (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(fall_w),
		.cancel_i(rise_w),
		.load_i(off_load_w),
		.busy_o(),
		.done_o(off_done)
	);

	wire cyc_end_w = cyc_q == TW'(PERIOD - 1);
	wire blocked_w = cyc_q >= TW'(VIEW);
	// a check fails when armed and no drop seen in the blocked window
	wire check_fail_w = cyc_end_w && armed_q && !seen_drop_q;
	wire check_pass_w = cyc_end_w && armed_q && seen_drop_q;
	wire relay_en_w = flame_q && !(interlock_w && fault_q);

	// flame state follows timer expiries
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			above_q <= 1'b0;
			flame_q <= 1'b0;
		end
		else
		begin
			above_q <= above_w;
			if (on_done)
				flame_q <= 1'b1;
			else if (off_done)
				flame_q <= 1'b0;
		end
	end

	// check cycle counter and drop detection
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cyc_q <= '0;
			seen_drop_q <= 1'b0;
			armed_q <= 1'b0;
		end
		else
		begin
			cyc_q <= cyc_end_w ? '0 : cyc_q + TW'(1);
			if (cyc_end_w)
			begin
				seen_drop_q <= 1'b0;
				armed_q <= above_w;
			end
			else
			begin
				if (blocked_w && !above_w)
					seen_drop_q <= 1'b1;
				// arm while flame present in the viewing part
				if (!blocked_w)
					armed_q <= above_w;
			end
		end
	end

	// failure counting and latched fault
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			fails_q <= '0;
			fault_q <= 1'b0;
		end
		else
		begin
			if (check_fail_w)
				fails_q <= (fails_q == 2'(FAIL_LIMIT)) ? fails_q
					: fails_q + 2'h1;
			else if (check_pass_w)
				fails_q <= '0;
			// second failure in a row; held until reset
			if (check_fail_w && fails_q == 2'(FAIL_LIMIT - 1))
				fault_q <= 1'b1;
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			outs_q <= '0;
			panel_q <= '0;
			remote_q <= '0;
			volt_q <= 1'b0;
			curr_q <= 1'b0;
			block_q <= 1'b0;
		end
		else
		begin
			outs_q.fault_relay <= fault_q;
			outs_q.fault_led <= fault_q;
			outs_q.aux_flame_relay <= relay_en_w;
			outs_q.flame_on_relay <= relay_en_w;
			outs_q.aux_flame_led <= relay_en_w;
			outs_q.flame_on_led <= relay_en_w;
			outs_q.check_led <= blocked_w;
			// chopper drive for the blocked second
			block_q <= blocked_w;
			case (meter_sel_i)
				FST_METER_SIGNAL: panel_q <= flame_sig_w;
				FST_METER_SETPOINT: panel_q <= setpoint_i;
				default: panel_q <= '0;
			endcase
			remote_q <= flame_sig_w;
			volt_q <= !links_i.current_output_link;
			curr_q <= links_i.current_output_link;
		end
	end

	assign outs_o = outs_q;
	assign panel_meter_o = panel_q;
	assign remote_meter_o = remote_q;
	assign voltage_out_en_o = volt_q;
	assign current_out_en_o = curr_q;
	assign chopper_block_o = block_q;
endmodule

// file: fst_chk_sva.sv
`timescale 1ns/10ps
// watches the supervisor ports for relay, check and fault timing
module fst_chk
	import fst_pkg::*;
#(
	parameter int SIG_W = 8,
	parameter longint unsigned ON_SHORT = 10,
	parameter longint unsigned ON_LONG = 20,
	parameter longint unsigned OFF_SHORT = 32,
	parameter longint unsigned OFF_LONG = 65
)(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [SIG_W-1:0] gain1_signal_i,
	input wire logic [SIG_W-1:0] gain2_signal_i,
	input wire logic gain_select_i,
	input wire logic [SIG_W-1:0] setpoint_i,
	input wire fst_links_t links_i,
	input wire fst_outs_t outs_o,
	input wire logic [SIG_W-1:0] remote_meter_o,
	input wire logic voltage_out_en_o,
	input wire logic current_out_en_o,
	input wire logic chopper_block_o
);
	// selected channel, threshold test and strap delays
	wire [SIG_W-1:0] sel_w = gain_select_i ? gain2_signal_i : gain1_signal_i;
	wire above_w = sel_w > setpoint_i;
	wire [7:0] on_w = links_i.turn_on_delay_select ? 8'(ON_LONG)
		: 8'(ON_SHORT);
	wire [7:0] off_w = links_i.turn_off_delay_select ? 8'(OFF_LONG)
		: 8'(OFF_SHORT);
	logic ab_q;
	logic up_q;
	logic [7:0] run_q;
	// cycles since the level last crossed, saturating
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			{ab_q, up_q, run_q} <= '0;
		end
		else
		begin
			ab_q <= above_w;
			up_q <= 1'b1;
			run_q <= (above_w != ab_q) ? 8'h00 : run_q + {7'h00, run_q != 8'hFF};
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	a_single_output: assert property (up_q |->
		voltage_out_en_o != current_out_en_o)
		else $error("output kind not exclusive");
	a_relay_pair: assert property (outs_o.aux_flame_relay == outs_o.flame_on_relay
		&& outs_o.flame_on_led == outs_o.flame_on_relay
		&& outs_o.aux_flame_led == outs_o.flame_on_relay)
		else $error("flame outputs disagree");
	a_check_pair: assert property (outs_o.check_led == chopper_block_o)
		else $error("check lamp differs from chopper");
	a_block_width: assert property ($rose(chopper_block_o) |->
		##9 chopper_block_o ##1 !chopper_block_o) else $error("block length wrong");
	a_check_period: assert property ($rose(chopper_block_o) |->
		##100 $rose(chopper_block_o)) else $error("check period wrong");
	// relays move two edges after the timer's last count; judge the
	// level and its run length at that edge, not after a later crossing
	a_on_delay: assert property ($rose(outs_o.flame_on_relay) |->
		$past(ab_q, 2) && $past(run_q, 2) >= on_w)
		else $error("relay on too early");
	a_off_delay: assert property ($fell(outs_o.flame_on_relay) &&
		!outs_o.fault_relay |-> !$past(ab_q, 2) && $past(run_q, 2) >= off_w)
		else $error("relay off too early");
	a_fault_hold: assert property (outs_o.fault_relay |=>
		outs_o.fault_relay && outs_o.fault_led) else $error("fault cleared");
	a_interlock_drop: assert property (outs_o.fault_led &&
		links_i.interlock_enable_link && !links_i.independent_relay_link
		|=> !outs_o.flame_on_relay) else $error("interlock ignored");
	a_remote_meter: assert property (up_q |-> remote_meter_o == $past(sel_w))
		else $error("remote meter wrong");
	c_flame_on: cover property ($rose(outs_o.flame_on_relay));
	c_fault: cover property ($rose(outs_o.fault_relay));
	c_check: cover property ($rose(chopper_block_o));
endmodule
bind fst_supervisor fst_chk #(.SIG_W(SIG_W), .ON_SHORT(ON_SHORT),
	.ON_LONG(ON_LONG), .OFF_SHORT(OFF_SHORT), .OFF_LONG(OFF_LONG)) i_fst_chk (
	.clk_i, .reset_n_i, .gain1_signal_i, .gain2_signal_i, .gain_select_i,
	.setpoint_i, .links_i, .outs_o, .remote_meter_o, .voltage_out_en_o,
	.current_out_en_o, .chopper_block_o);

// file: fst_scanner.sv
`timescale 1ns/10ps
// scanner with chopper vane; a stuck vane never darkens the view
module fst_scanner
	import fst_pkg::*;
(
	input wire logic clk_i,
	input wire logic block_i,
	input wire logic stuck_i,
	input wire logic [7:0] level_i,
	output logic [7:0] gain1_o,
	output logic [7:0] gain2_o
);
	// dark while blocked, channel two at half gain
	always_ff @(posedge clk_i)
	begin
		gain1_o <= (block_i && !stuck_i) ? 8'h00 : level_i;
		gain2_o <= (block_i && !stuck_i) ? 8'h00 : level_i >> 1;
	end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
	import fst_pkg::*;
	localparam longint unsigned ONS = 10, ONL = 20, OFS = 32, OFL = 65;
	logic clk_i = 0, reset_n_i = 0, gain_select_i = 0, stuck = 1;
	logic [7:0] g1, g2, setpoint_i = 8'h40, level = 8'h00;
	fst_meter_sel_t meter_sel_i = FST_METER_SIGNAL;
	fst_links_t links_i = '0;
	fst_outs_t outs_o;
	logic [7:0] panel_meter_o, remote_meter_o;
	logic volt_en, cur_en, block;
	int miscompares = 0, tests_run = 0, cycles = 0, on, off;
	always #2 clk_i = ~clk_i;
	fst_supervisor #(.ON_SHORT(ONS), .ON_LONG(ONL), .OFF_SHORT(OFS),
		.OFF_LONG(OFL), .PERIOD(100), .VIEW(90)) i_fst_supervisor (.clk_i,
		.reset_n_i, .gain1_signal_i(g1), .gain2_signal_i(g2), .gain_select_i,
		.setpoint_i, .meter_sel_i, .links_i, .outs_o, .panel_meter_o,
		.remote_meter_o, .voltage_out_en_o(volt_en), .current_out_en_o(cur_en),
		.chopper_block_o(block));
	fst_scanner i_fst_scanner (.clk_i, .block_i(block), .stuck_i(stuck),
		.level_i(level), .gain1_o(g1), .gain2_o(g2));
	task summarize;
		$display("compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			summarize();
		end
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task rst(input fst_links_t l);
		reset_n_i = 0;
		links_i = l;
		level = 8'h00;
		stuck = 1;
		step(2);
		reset_n_i = 1;
	endtask
	function automatic logic [7:0] mexp(fst_meter_sel_t s, logic [7:0] v, sp);
		return s == FST_METER_SIGNAL ? v : s == FST_METER_SETPOINT ? sp : 8'h00;
	endfunction
	initial
	begin
		void'($urandom(32'h53d1));
		rst('0);
		// meter routing, gain channel and output kind
		repeat (12)
		begin
			links_i.current_output_link = 1'($urandom);
			gain_select_i = 1'($urandom);
			meter_sel_i = fst_meter_sel_t'($urandom_range(0, 3));
			level = 8'($urandom);
			setpoint_i = 8'($urandom);
			step(3);
			chk(panel_meter_o, mexp(meter_sel_i, gain_select_i ? level >> 1 : level,
				setpoint_i));
			chk(remote_meter_o, gain_select_i ? level >> 1 : level);
			chk({volt_en, cur_en}, {~links_i.current_output_link,
				links_i.current_output_link});
		end
		$display("done: meter");
		setpoint_i = 8'h40;
		gain_select_i = 0;
		// both delays under every setting of the two delay straps
		for (int i = 0; i < 4; i++)
		begin
			rst(fst_links_t'({i[0], i[1], 3'h0}));
			on = i[0] ? int'(ONL) : int'(ONS);
			off = i[1] ? int'(OFL) : int'(OFS);
			level = 8'h80 | 8'($urandom);
			step(on);
			chk(outs_o.flame_on_relay, 1'h0);
			step(6);
			chk(outs_o.flame_on_relay, 1'h1);
			level = 8'($urandom_range(0, 64));
			step(off);
			chk(outs_o.flame_on_relay, 1'h1);
			step(6);
			chk(outs_o.flame_on_relay, 1'h0);
		end
		$display("done: delays");
		// a short dip restarts the on timer
		rst('0);
		level = 8'hC0;
		step(5);
		level = 8'h10;
		step(2);
		level = 8'hC0;
		step(7);
		chk(outs_o.flame_on_relay, 1'h0);
		step(9);
		chk(outs_o.flame_on_relay, 1'h1);
		// healthy scanner rides through every blocked second
		stuck = 0;
		repeat (300)
		begin
			step(1);
			chk(outs_o.flame_on_relay, 1'h1);
		end
		chk(outs_o.fault_relay, 1'h0);
		// flame over each blocked second and two cycles past it, dark at the last viewing
		// sample: disarmed again before each check, so two undropped blocked seconds are not judged
		rst('0);
		level = 8'h10;
		step(89);
		repeat (2)
		begin
			level = 8'hC0;
			step(12);
			level = 8'h10;
			step(88);
		end
		chk(outs_o.fault_relay, 1'h0);
		$display("done: ride and arm");
		// stuck vane, first independent then interlocked relays
		for (int i = 0; i < 2; i++)
		begin
			rst(i ? 5'h04 : 5'h02);
			level = 8'hC0;
			step(260);
			chk(outs_o.fault_led, 1'h1);
			chk(outs_o.flame_on_relay, i ? 1'h0 : 1'h1);
			stuck = 0;
			step(200);
			chk(outs_o.fault_relay, 1'h1);
		end
		$display("done: fault");
		summarize();
	end
endmodule
